// ===== design/hbgc_pkg.sv
// package for the h-bridge gate control block
// assumes a single 25 MHz clock domain
package hbgc_pkg;

  // ==========================================================
  // clock and timing
  localparam int          CLK_HZ           = 25000000;
  localparam int          STEP_UP_HZ       = 100000;
  localparam int          STEP_UP_HALF_CYC = CLK_HZ / (2 * STEP_UP_HZ);
  localparam int          SHORT_DETECT_NS  = 10000;
  localparam int          SHORT_DETECT_CYC = (SHORT_DETECT_NS + 39) / 40;
  localparam int          DEAD_TIME_NS     = 1000;
  localparam int          DEAD_TIME_CYC    = (DEAD_TIME_NS + 39) / 40;
  localparam int          SLOW_ON_EXTRA    = 2;
  localparam logic [7:0]  HALF_CYC_W       = 8'(STEP_UP_HALF_CYC - 1);
  localparam logic [9:0]  SHORT_CYC_W      = 10'(SHORT_DETECT_CYC);
  localparam logic [6:0]  DEAD_CYC_W       = 7'(DEAD_TIME_CYC + SLOW_ON_EXTRA);

  // ==========================================================
  // register bus map (byte addresses)
  localparam logic [3:0]  ADDR_CTRL        = 4'h0;
  localparam logic [3:0]  ADDR_STATUS      = 4'h4;
  localparam logic [3:0]  ADDR_IRQ_STAT    = 4'h8;
  localparam logic [3:0]  ADDR_IRQ_MASK    = 4'hC;
  localparam logic [31:0] BAD_ADDR_DATA    = 32'h0000_0000;

  // ctrl fields
  localparam int          CTRL_EN_BIT      = 0;
  localparam int          CTRL_DIR_BIT     = 1;
  localparam int          CTRL_PWM_BIT     = 2;
  localparam logic [2:0]  CTRL_RESET_VAL   = 3'h6;

  // event bits: 0 overtemp 1 overvolt 2 undervolt 3 short
  localparam int          EVT_W            = 4;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    HBGC_STANDBY = 2'b00,
    HBGC_FAULT   = 2'b01,
    HBGC_RUN     = 2'b10
  } hbgc_mode_t;

  typedef struct packed {
    logic hs_a;
    logic ls_a;
    logic hs_b;
    logic ls_b;
  } hbgc_gates_t;

endpackage : hbgc_pkg

// ===== design/hbgc_top.sv
// h-bridge gate control: decode, fault shutdown, short latch, step-up clock
// assumes comparator flags are asynchronous pins; wishbone master on CLK_IN
`timescale 1ns/1ns

// Operation
// RULE1 - step-up switch toggles at 100 kHz, half high half low, while active
// RULE2 - step-up starts when supply below 8V, stops above 10V
// RULE3 - enable low: gates resistive, fault flag tristated; enable high activates
// RULE4 - controller waits about 50 us after enable before relying on bridge
// RULE5 - unconnected direction or pulse-width input reads as high
// RULE6 - controller holds direction and pulse-width high at wake, brake, disable
// RULE7 - pulse-width high brakes: both high sides sink, both low sides source
// RULE8 - pulse-width low: direction picks diagonal pair, other gates sink
// RULE9 - over-temperature forces gates sink, serial driver off, fault low
// RULE10 - overvoltage forces gates sink, serial driver off, fault low
// RULE11 - undervoltage keeps gates sink and fault low
// RULE12 - high side held on with low node past detect time is cut off
// RULE13 - low side held on with high node past detect time is cut off
// RULE14 - cut-off latch holds fault low until direction or pulse-width changes
// RULE15 - short cut-off affects only shorted transistors, others follow inputs
// RULE16 - fault flag low is real-time OR of all shutdown conditions
// RULE17 - turn-on delayed longer than turn-off to avoid cross conduction
// RULE18 - each turn-on waits a dead time after input change
// RULE19 - flags synchronised; faults beat decoding; standby beats all
module hbgc_top (
  input  wire logic               CLK_IN,
  input  wire logic               RSTN_IN,
  input  wire logic               WB_CYC_IN,
  input  wire logic               WB_STB_IN,
  input  wire logic               WB_WE_IN,
  input  wire logic [3:0]         WB_ADR_IN,
  input  wire logic [3:0]         WB_SEL_IN,
  input  wire logic [31:0]        WB_DAT_IN,
  output logic      [31:0]        WB_DAT_OUT,
  output logic                    WB_ACK_OUT,
  input  wire logic               OVERTEMP_FLAG_IN,
  input  wire logic               OVERVOLT_FLAG_IN,
  input  wire logic               UNDERVOLT_FLAG_IN,
  input  wire logic               SUPPLY_BELOW_8V_IN,
  input  wire logic               SUPPLY_ABOVE_10V_IN,
  input  wire logic               BRIDGE_NODE_A_HIGH_IN,
  input  wire logic               BRIDGE_NODE_B_HIGH_IN,
  output hbgc_pkg::hbgc_gates_t   GATES_OUT,
  output logic                    GATES_RESISTIVE_OUT,
  output logic                    FAULT_FLAG_N_OUT,
  output logic                    FAULT_FLAG_N_OE_OUT,
  output logic                    STEP_UP_SWITCH_OUT,
  output logic                    SERIAL_DRIVER_EN_OUT,
  output logic                    IRQ_OUT
);
  import hbgc_pkg::*;

  // ==========================================================
  // input synchronisers
  // two flops per pin; only the second flop feeds logic
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic [NSYNC-1:0] pins;
  assign pins = {OVERTEMP_FLAG_IN, OVERVOLT_FLAG_IN, UNDERVOLT_FLAG_IN, SUPPLY_BELOW_8V_IN,
                 SUPPLY_ABOVE_10V_IN, BRIDGE_NODE_A_HIGH_IN, BRIDGE_NODE_B_HIGH_IN};

  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= pins[gi];                               // RULE19
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic ot_s, ov_s, uv_s, below8_s, above10_s, node_a_hi, node_b_hi;
  assign {ot_s, ov_s, uv_s, below8_s, above10_s, node_a_hi, node_b_hi} = sync2_reg;

  // ==========================================================
  // wishbone register file
  logic [2:0]       ctrl_reg;
  logic [EVT_W-1:0] irq_stat_reg;
  logic [EVT_W-1:0] irq_mask_reg;
  logic             ack_reg;
  logic [31:0]      dat_reg;
  logic             bus_req;
  logic             wr_ctrl;
  logic             rd_irq;
  logic             wr_mask;
  logic             enable, dir_in, pwm_in;

  // write strobe for one register word; byte lane 0 carries every field
  function automatic logic wr_hit(input logic       req,
                                  input logic       we,
                                  input logic       sel0,
                                  input logic [3:0] adr,
                                  input logic [3:0] target);
    return req && we && sel0 && (adr == target);
  endfunction : wr_hit

  assign bus_req = WB_CYC_IN && WB_STB_IN && !ack_reg;
  assign wr_ctrl = wr_hit(bus_req, WB_WE_IN, WB_SEL_IN[0], WB_ADR_IN, ADDR_CTRL);
  assign wr_mask = wr_hit(bus_req, WB_WE_IN, WB_SEL_IN[0], WB_ADR_IN, ADDR_IRQ_MASK);
  assign rd_irq  = bus_req && !WB_WE_IN && (WB_ADR_IN == ADDR_IRQ_STAT);
  assign enable  = ctrl_reg[CTRL_EN_BIT];
  assign dir_in  = ctrl_reg[CTRL_DIR_BIT];
  assign pwm_in  = ctrl_reg[CTRL_PWM_BIT];

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      ctrl_reg <= CTRL_RESET_VAL;                                  // RULE3 RULE5
    end else if (wr_ctrl) begin
      ctrl_reg <= WB_DAT_IN[2:0];
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      irq_mask_reg <= '0;
    end else if (wr_mask) begin
      irq_mask_reg <= WB_DAT_IN[EVT_W-1:0];
    end
  end

  // ==========================================================
  // fault evaluation
  logic             hw_fault;
  logic [3:0]       short_lat_reg;   // hs_a ls_a hs_b ls_b
  logic             short_any;
  logic [EVT_W-1:0] events;
  logic [EVT_W-1:0] events_d_reg;

  assign hw_fault  = ot_s || ov_s || uv_s;                         // RULE9 RULE10 RULE11
  assign short_any = |short_lat_reg;
  assign events    = enable ? {short_any, uv_s, ov_s, ot_s} : '0;

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      events_d_reg <= '0;
    end else begin
      events_d_reg <= events;
    end
  end

  // set wins over read-clear, so an event in the read cycle shows on the next read
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (rd_irq ? '0 : irq_stat_reg) | (events & ~events_d_reg);
    end
  end

  // single-cycle ack; the ack term in bus_req drops it after one cycle
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req;
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      dat_reg <= '0;
    end else begin
      if (bus_req && !WB_WE_IN) begin
        case (WB_ADR_IN)
          ADDR_CTRL:     dat_reg <= {29'h0000_0000, ctrl_reg};
          ADDR_STATUS:   dat_reg <= {24'h00_0000, short_lat_reg, short_any, uv_s, ov_s, ot_s};
          ADDR_IRQ_STAT: dat_reg <= {28'h000_0000, irq_stat_reg};
          ADDR_IRQ_MASK: dat_reg <= {28'h000_0000, irq_mask_reg};
          default:       dat_reg <= BAD_ADDR_DATA;
        endcase
      end
    end
  end

  assign WB_ACK_OUT = ack_reg;
  assign WB_DAT_OUT = dat_reg;

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      IRQ_OUT <= 1'b0;
    end else begin
      IRQ_OUT <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // ==========================================================
  // mode and truth-table decode
  hbgc_mode_t  mode;
  hbgc_gates_t want;
  always_comb begin
    if (!enable) begin
      mode = HBGC_STANDBY;                                         // RULE19
    end else if (hw_fault) begin
      mode = HBGC_FAULT;
    end else begin
      mode = HBGC_RUN;
    end
  end

  always_comb begin
    want = '0;
    case (mode)
      HBGC_RUN: begin
        if (pwm_in) begin
          want = '{hs_a: 1'b0, ls_a: 1'b1, hs_b: 1'b0, ls_b: 1'b1}; // RULE7
        end else if (!dir_in) begin
          want = '{hs_a: 1'b0, ls_a: 1'b1, hs_b: 1'b1, ls_b: 1'b0}; // RULE8
        end else begin
          want = '{hs_a: 1'b1, ls_a: 1'b0, hs_b: 1'b0, ls_b: 1'b1}; // RULE8
        end
      end
      default: want = '0;                                          // RULE9 RULE10 RULE11
    endcase
  end

  // ==========================================================
  // dead time after input change, short latches
  logic [1:0] inputs_d_reg;
  logic       input_change;
  logic [6:0] dead_cnt_reg;
  logic       dead_busy;
  assign input_change = {dir_in, pwm_in} != inputs_d_reg;
  // busy from the very cycle of the change, before the counter is loaded
  assign dead_busy    = input_change || (dead_cnt_reg != 7'h00);

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      inputs_d_reg <= 2'h3;
      dead_cnt_reg <= '0;
    end else begin
      inputs_d_reg <= {dir_in, pwm_in};
      if (input_change || !enable) begin
        dead_cnt_reg <= DEAD_CYC_W;                                // RULE18 RULE17
      end else if (dead_busy) begin
        dead_cnt_reg <= dead_cnt_reg - 7'h01;
      end
    end
  end

  hbgc_gates_t gate_reg;
  logic [3:0]  gate_vec;
  logic [3:0]  node_bad;
  assign gate_vec = gate_reg;
  // high side shorted if node stays low; low side if node stays high
  assign node_bad = {!node_a_hi, node_a_hi, !node_b_hi, node_b_hi};

  // per-switch run counter, cleared when the switch drops or the node recovers
  logic [9:0] sc_cnt_reg [4];
  generate
    for (gi = 0; gi < 4; gi++) begin : g_short
      always_ff @(posedge CLK_IN) begin
        if (!RSTN_IN) begin
          sc_cnt_reg[gi]    <= '0;
          short_lat_reg[gi] <= 1'b0;
        end else if (input_change || !enable) begin
          sc_cnt_reg[gi]    <= '0;
          short_lat_reg[gi] <= 1'b0;                               // RULE14
        end else if (gate_vec[gi] && node_bad[gi]) begin
          if (sc_cnt_reg[gi] >= SHORT_CYC_W) begin
            short_lat_reg[gi] <= 1'b1;                             // RULE12 RULE13
          end else begin
            sc_cnt_reg[gi] <= sc_cnt_reg[gi] + 10'h001;
          end
        end else begin
          sc_cnt_reg[gi] <= '0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // gate and flag outputs
  logic [3:0] want_vec;
  logic       fault_any;
  assign want_vec  = want;
  assign fault_any = hw_fault || short_any;

  // last guard: never both switches of one leg at once
  function automatic logic [3:0] leg_guard(input logic [3:0] g);
    logic [3:0] r;
    r = g;
    if (g[3] && g[2]) begin
      r[3:2] = 2'b00;
    end
    if (g[1] && g[0]) begin
      r[1:0] = 2'b00;
    end
    return r;
  endfunction : leg_guard

  // turn-off at once, turn-on only when the dead time is over; latched shorts stay off
  function automatic logic [3:0] gate_next(input logic [3:0] wanted,
                                           input logic [3:0] held,
                                           input logic [3:0] latched,
                                           input logic       busy);
    return leg_guard(wanted & ~latched & (busy ? held : 4'hF));
  endfunction : gate_next

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      gate_reg <= '0;
    end else begin
      gate_reg <= gate_next(want_vec, gate_vec, short_lat_reg, dead_busy); // RULE15 RULE17 RULE18
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      GATES_OUT           <= '0;
      GATES_RESISTIVE_OUT <= 1'b1;
    end else begin
      GATES_OUT           <= gate_next(want_vec, gate_vec, short_lat_reg, dead_busy);
      GATES_RESISTIVE_OUT <= !enable;                                // RULE3
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      FAULT_FLAG_N_OUT <= 1'b1;
    end else begin
      FAULT_FLAG_N_OUT <= !fault_any;                                // RULE16
    end
  end

  // open drain: driven only when enabled and pulling low
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      FAULT_FLAG_N_OE_OUT <= 1'b0;
    end else begin
      FAULT_FLAG_N_OE_OUT <= enable && fault_any;                    // RULE3 RULE16
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      SERIAL_DRIVER_EN_OUT <= 1'b0;
    end else begin
      SERIAL_DRIVER_EN_OUT <= enable && !ot_s && !ov_s;              // RULE9 RULE10
    end
  end

  // ==========================================================
  // step-up converter switch
  // below-8V start and above-10V stop form the hysteresis band
  logic       stepup_on_reg;
  logic [7:0] su_cnt_reg;
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      stepup_on_reg <= 1'b0;
    end else if (!enable || above10_s) begin
      stepup_on_reg <= 1'b0;                                       // RULE2
    end else if (below8_s) begin
      stepup_on_reg <= 1'b1;                                       // RULE2
    end
  end

  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN) begin
      su_cnt_reg         <= '0;
      STEP_UP_SWITCH_OUT <= 1'b0;
    end else if (!stepup_on_reg) begin
      su_cnt_reg         <= '0;
      STEP_UP_SWITCH_OUT <= 1'b0;
    end else if (su_cnt_reg == HALF_CYC_W) begin
      su_cnt_reg         <= '0;
      STEP_UP_SWITCH_OUT <= !STEP_UP_SWITCH_OUT;                   // RULE1
    end else begin
      su_cnt_reg <= su_cnt_reg + 8'h01;
    end
  end

endmodule : hbgc_top

// ===== bench/hbgc_props.sv
// checker: pin-level properties of hbgc_top
// assumes a bind from tb_top and one clock domain
`timescale 1ns/1ns
module hbgc_props (
  input wire logic                  CLK_IN,
  input wire logic                  RSTN_IN,
  input wire logic                  OVERTEMP_FLAG_IN,
  input wire logic                  OVERVOLT_FLAG_IN,
  input wire logic                  UNDERVOLT_FLAG_IN,
  input wire logic                  BRIDGE_NODE_B_HIGH_IN,
  input wire hbgc_pkg::hbgc_gates_t GATES_OUT,
  input wire logic                  GATES_RESISTIVE_OUT,
  input wire logic                  FAULT_FLAG_N_OUT,
  input wire logic                  FAULT_FLAG_N_OE_OUT,
  input wire logic                  STEP_UP_SWITCH_OUT,
  input wire logic                  SERIAL_DRIVER_EN_OUT
);
  import hbgc_pkg::*;
  logic [9:0] hs_cnt_reg;
  logic [7:0] st_cnt_reg;
  default clocking dc @(posedge CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  // ==========
  // run lengths: high side on into a low node, step-up high
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || !GATES_OUT.hs_b || BRIDGE_NODE_B_HIGH_IN)
      hs_cnt_reg <= 10'h000;
    else
      hs_cnt_reg <= hs_cnt_reg + 10'h001;
  end
  always_ff @(posedge CLK_IN) begin
    if (!RSTN_IN || !STEP_UP_SWITCH_OUT)
      st_cnt_reg <= 8'h00;
    else
      st_cnt_reg <= st_cnt_reg + 8'h01;
  end
  // ==========
  // properties
  sequence s_held(f);
    f [*6];
  endsequence
  property p_off(f, k);
    s_held(f) ##1 !GATES_RESISTIVE_OUT |-> GATES_OUT == 4'h0 && !FAULT_FLAG_N_OUT && !(k && SERIAL_DRIVER_EN_OUT);
  endproperty
  AST_OT: assert property (p_off(OVERTEMP_FLAG_IN, 1'b1))
    else $error("gates on under overtemp");
  AST_OV: assert property (p_off(OVERVOLT_FLAG_IN, 1'b1))
    else $error("gates on under overvolt");
  AST_UV: assert property (p_off(UNDERVOLT_FLAG_IN, 1'b0))
    else $error("gates on under undervolt");
  AST_STANDBY: assert property (GATES_RESISTIVE_OUT |-> GATES_OUT == 4'h0 && !FAULT_FLAG_N_OE_OUT)
    else $error("standby outputs wrong");
  AST_FLAG_OD: assert property (FAULT_FLAG_N_OE_OUT |-> !FAULT_FLAG_N_OUT)
    else $error("fault pin driven high");
  AST_NO_SHOOT: assert property (!(GATES_OUT.hs_a && GATES_OUT.ls_a) && !(GATES_OUT.hs_b && GATES_OUT.ls_b))
    else $error("both gates of a leg on");
  AST_DEAD: assert property ($fell(GATES_OUT.ls_a) |=> !GATES_OUT.hs_a [*8])
    else $error("high side on too soon");
  AST_SHORT: assert property (hs_cnt_reg < 10'h106)
    else $error("shorted high side not cut");
  AST_STEP: assert property (st_cnt_reg <= 8'h7D)
    else $error("step-up high too long");
endmodule : hbgc_props

// ===== bench/hbgc_bridge_model.sv
// bench model of the two bridge nodes behind the gates
// assumes gate struct from hbgc_top; shorts come from tb_top
`timescale 1ns/1ns
module hbgc_bridge_model (
  input  wire logic                  clk_in,
  input  wire hbgc_pkg::hbgc_gates_t gates_in,
  input  wire logic                  gnd_b_in,
  input  wire logic                  bat_b_in,
  output logic                       node_a_out,
  output logic                       node_b_out
);
  import hbgc_pkg::*;
  // ==========
  // undriven node wanders every cycle
  logic wander_reg = 1'b0;
  always_ff @(posedge clk_in) begin
    wander_reg <= !wander_reg;
  end
  assign node_a_out = gates_in.hs_a || (!gates_in.ls_a && wander_reg);
  assign node_b_out = !gnd_b_in && (bat_b_in || gates_in.hs_b || (!gates_in.ls_b && wander_reg));
endmodule : hbgc_bridge_model

// ===== bench/tb_top.sv
// bench for hbgc_top: bus, decode, faults, short latch, step-up
// assumes hbgc_props and hbgc_bridge_model are compiled
`timescale 1ns/1ns
module tb_top;
  import hbgc_pkg::*;
  logic        clk, rstn, cyc, stb, we, ot, ov, uv, lo8, hi10, sgb, sbb;
  logic        ack, na, nb, res, fn, foe, stp, ser, irq;
  logic [3:0]  adr;
  logic [31:0] dat, rdat, r;
  logic [31:0] exp_q[$];
  hbgc_gates_t g;
  int          n_fail, n_tests, n;
  logic [2:0]  ctl[3] = '{3'h1, 3'h3, 3'h7};
  logic [3:0]  gt[4] = '{4'h5, 4'h6, 4'h9, 4'h5};
  hbgc_top dut (.CLK_IN(clk), .RSTN_IN(rstn), .WB_CYC_IN(cyc), .WB_STB_IN(stb), .WB_WE_IN(we),
    .WB_ADR_IN(adr), .WB_SEL_IN(4'hF), .WB_DAT_IN(dat), .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack),
    .OVERTEMP_FLAG_IN(ot), .OVERVOLT_FLAG_IN(ov), .UNDERVOLT_FLAG_IN(uv), .SUPPLY_BELOW_8V_IN(lo8),
    .SUPPLY_ABOVE_10V_IN(hi10), .BRIDGE_NODE_A_HIGH_IN(na), .BRIDGE_NODE_B_HIGH_IN(nb), .GATES_OUT(g),
    .GATES_RESISTIVE_OUT(res), .FAULT_FLAG_N_OUT(fn), .FAULT_FLAG_N_OE_OUT(foe),
    .STEP_UP_SWITCH_OUT(stp), .SERIAL_DRIVER_EN_OUT(ser), .IRQ_OUT(irq));
  hbgc_bridge_model u_bridge (.clk_in(clk), .gates_in(g), .gnd_b_in(sgb), .bat_b_in(sbb),
    .node_a_out(na), .node_b_out(nb));
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  // ==========
  // checking
  task automatic cmp(input logic [31:0] got, input logic [31:0] want);
    n_tests++;
    if (got !== want) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, want);
    end
  endtask : cmp
  task automatic pins(input logic [6:0] e);
    @(negedge clk);
    cmp({25'h0, res, foe, fn, g}, {25'h0, e});
  endtask : pins
  task automatic report_and_stop;
    if (n_fail == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : report_and_stop
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0)
      cmp(rdat, exp_q.pop_front());
  end
  // ==========
  // stimulus
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    if (!w)
      exp_q.push_back(d);
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (ack === 1'b1)
        break;
    end
    if (n == 20) begin
      n_fail++;
      report_and_stop();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic run_len(input logic v, input logic hard);
    for (n = 0; n < 400 && stp === v; n++)
      @(negedge clk);
    if (hard && n == 400) begin
      n_fail++;
      report_and_stop();
    end
  endtask : run_len
  initial begin
    {rstn, cyc, stb, we, ot, ov, uv, lo8, hi10, sgb, sbb} = 11'h000;
    adr = 4'h0;
    dat = 32'h0;
    n_fail = 0;
    n_tests = 0;
    r = $urandom(32'h3D79859F);
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    pins(7'h50);
    wb(1'b0, ADDR_CTRL, 32'h6);
    wb(1'b1, ADDR_CTRL, 32'h7);
    repeat (1250) @(posedge clk);
    pins(7'h15);
    for (int i = 0; i < 3; i++) begin
      wb(1'b1, ADDR_CTRL, {29'h0, ctl[i]});
      repeat (10) @(posedge clk);
      pins({3'h1, gt[i] & gt[i + 1]});
      repeat (30) @(posedge clk);
      pins({3'h1, gt[i + 1]});
    end
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      {uv, ov, ot} <= 3'(1 << i);
      repeat (8) @(posedge clk);
      pins(7'h20);
      cmp({31'h0, ser}, {31'h0, i == 2});
      wb(1'b0, ADDR_STATUS, 32'(1 << i));
      {uv, ov, ot} <= 3'h0;
      repeat (40) @(posedge clk);
      pins(7'h15);
    end
    cmp({31'h0, irq}, 32'h0);
    wb(1'b0, ADDR_IRQ_STAT, 32'h7);
    wb(1'b0, ADDR_IRQ_STAT, 32'h0);
    wb(1'b1, ADDR_IRQ_MASK, {28'h0, r[3:1], 1'b1});
    wb(1'b0, ADDR_IRQ_MASK, {28'h0, r[3:1], 1'b1});
    ot <= 1'b1;
    repeat (8) @(posedge clk);
    ot <= 1'b0;
    cmp({31'h0, irq}, 32'h1);
    wb(1'b0, ADDR_IRQ_STAT, 32'h1);
    repeat (3) @(posedge clk);
    cmp({31'h0, irq}, 32'h0);
    wb(1'b1, ADDR_CTRL, 32'h1);
    repeat (40) @(posedge clk);
    sgb <= 1'b1;
    repeat (300) @(posedge clk);
    pins(7'h24);
    wb(1'b0, ADDR_STATUS, 32'h28);
    sgb <= 1'b0;
    repeat (40) @(posedge clk);
    pins(7'h24);
    wb(1'b1, ADDR_CTRL, 32'h3);
    repeat (40) @(posedge clk);
    pins(7'h19);
    @(posedge clk);
    sbb <= 1'b1;
    repeat (300) @(posedge clk);
    pins(7'h28);
    @(posedge clk);
    sbb <= 1'b0;
    wb(1'b1, ADDR_CTRL, 32'h7);
    repeat (40) @(posedge clk);
    pins(7'h15);
    @(posedge clk);
    lo8 <= 1'b1;
    run_len(1'b0, 1'b1);
    run_len(1'b1, 1'b1);
    cmp(n, 125);
    run_len(1'b0, 1'b1);
    cmp(n, 125);
    @(posedge clk);
    lo8 <= 1'b0;
    run_len(1'b1, 1'b1);
    run_len(1'b0, 1'b1);
    cmp(n, 125);
    @(posedge clk);
    hi10 <= 1'b1;
    run_len(1'b1, 1'b1);
    run_len(1'b0, 1'b0);
    cmp(n, 400);
    wb(1'b1, ADDR_CTRL, 32'h6);
    repeat (40) @(posedge clk);
    pins(7'h50);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    wb(1'b0, ADDR_IRQ_MASK, 32'h0);
    report_and_stop();
  end
endmodule : tb_top
bind hbgc_top hbgc_props u_props (.CLK_IN(CLK_IN), .RSTN_IN(RSTN_IN), .OVERTEMP_FLAG_IN(OVERTEMP_FLAG_IN),
  .OVERVOLT_FLAG_IN(OVERVOLT_FLAG_IN), .UNDERVOLT_FLAG_IN(UNDERVOLT_FLAG_IN), .GATES_OUT(GATES_OUT),
  .BRIDGE_NODE_B_HIGH_IN(BRIDGE_NODE_B_HIGH_IN), .GATES_RESISTIVE_OUT(GATES_RESISTIVE_OUT),
  .FAULT_FLAG_N_OUT(FAULT_FLAG_N_OUT), .FAULT_FLAG_N_OE_OUT(FAULT_FLAG_N_OE_OUT),
  .STEP_UP_SWITCH_OUT(STEP_UP_SWITCH_OUT), .SERIAL_DRIVER_EN_OUT(SERIAL_DRIVER_EN_OUT));
